// ==== hw/bmsu_defines.vh ====
// Constants shared by the multiply, divide, bit count and shift unit
`ifndef BMSU_DEFINES_VH
`define BMSU_DEFINES_VH

// Data widths
`define BMSU_ACC_W      32
`define BMSU_OPD_W      16
`define BMSU_ADDR_W     16
`define BMSU_CNT_W      6

// Operation codes on op_i
`define BMSU_OP_MUL     3'h0
`define BMSU_OP_DIV     3'h1
`define BMSU_OP_POPCNT  3'h2
`define BMSU_OP_SHL     3'h3
`define BMSU_OP_SHR     3'h4

// Operand source codes on src_i
`define BMSU_SRC_DIRECT 2'h0
`define BMSU_SRC_PTR    2'h1
`define BMSU_SRC_IMM    2'h2

// Divider step count, one quotient bit per cycle
`define BMSU_DIV_STEPS  5'h10
`define BMSU_DIV_LAST   5'h0f

// Bit position of the sign in the accumulator
`define BMSU_SIGN_BIT   31

`endif

// ==== hw/bmsu_divider.v ====
// Sequential restoring divider, 16 by 16 bits, one quotient bit per cycle
`timescale 1ns/1ps
`include "bmsu_defines.vh"

module bmsu_divider #(
    parameter W = `BMSU_OPD_W                  // Operand width
) (
    input  wire         core_clk_i,            // Core clock
    input  wire         rst_i,                 // Asynchronous reset, active high
    input  wire         start_i,               // One-cycle start pulse
    input  wire [W-1:0] dividend_i,            // Dividend, sampled on start
    input  wire [W-1:0] divisor_i,             // Divisor, sampled on start, nonzero
    output reg          done_o,                // One-cycle pulse, results valid
    output reg  [W-1:0] quot_o,                // Quotient
    output reg  [W-1:0] rem_o                  // Remainder
);

    reg         run_q;
    reg [4:0]   step_q;
    reg [W-1:0] dvs_q;
    reg [W-1:0] quo_q;
    reg [W-1:0] rem_q;
    reg [W:0]   shifted;
    reg [W:0]   trial;
    reg         fits;

    // Shift in the next dividend bit and try to subtract the divisor
    always @* begin
        shifted = {rem_q, quo_q[W-1]};
        trial   = shifted - {1'b0, dvs_q};
        fits    = (shifted >= {1'b0, dvs_q});
    end

    // Iteration; a zero divisor is filtered out by the caller
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_q  <= 1'b0;
            step_q <= 5'h00;
            dvs_q  <= {W{1'b0}};
            quo_q  <= {W{1'b0}};
            rem_q  <= {W{1'b0}};
            done_o <= 1'b0;
            quot_o <= {W{1'b0}};
            rem_o  <= {W{1'b0}};
        end else begin
            done_o <= 1'b0;
            if (start_i && !run_q) begin
                run_q  <= 1'b1;
                step_q <= 5'h00;
                dvs_q  <= divisor_i;
                quo_q  <= dividend_i;
                rem_q  <= {W{1'b0}};
            end else if (run_q) begin
                rem_q  <= fits ? trial[W-1:0] : shifted[W-1:0];
                quo_q  <= {quo_q[W-2:0], fits};
                step_q <= step_q + 5'h01;
                if (step_q == `BMSU_DIV_LAST) begin
                    run_q  <= 1'b0;
                    done_o <= 1'b1;
                    quot_o <= {quo_q[W-2:0], fits};
                    rem_o  <= fits ? trial[W-1:0] : shifted[W-1:0];
                end
            end
        end
    end

endmodule // bmsu_divider

// ==== hw/bmsu_unit.v ====
// Accumulator execution unit: binary multiply, divide, bit count and shifts
`timescale 1ns/1ps
`include "bmsu_defines.vh"

// How it works
// - Multiply operand by accumulator, 32-bit product
// - Operand from memory, pointer or immediate
// - Divide accumulator by operand, quotient to accumulator
// - Remainder written to first stack location
// - Divide sets range error on unusable operand
// - Zero flag follows the resulting accumulator
// - Negative flag set when result negative
// - Flags hold until next affecting instruction
// - Bit count replaces accumulator with ones count
// - Shift left 32 bits, zero fill, discard
// - Shift right 32 bits, zero fill, drop
// - Shift count from memory or immediate only
module bmsu_unit #(
    parameter AW = `BMSU_ADDR_W                // Data memory address width
) (
    input  wire        core_clk_i,             // Core clock, 40 MHz
    input  wire        rst_i,                  // Asynchronous reset, active high
    input  wire        start_i,                // One-cycle instruction start pulse
    input  wire [2:0]  op_i,                   // Operation code
    input  wire [1:0]  src_i,                  // Operand source
    input  wire [15:0] imm_i,                  // Immediate operand
    input  wire [AW-1:0] addr_i,               // Direct or pointer address
    input  wire        acc_ld_i,               // Load accumulator from outside
    input  wire [31:0] acc_ld_data_i,          // Accumulator load value
    input  wire [15:0] mem_rdata_i,            // Memory data, cycle after read
    output reg         mem_rd_o,               // Memory read strobe
    output reg  [AW-1:0] mem_addr_o,           // Memory read address
    output reg  [31:0] acc_o,                  // Accumulator
    output reg         stack_wr_o,             // First stack location write pulse
    output reg  [31:0] stack_data_o,           // Value for first stack location
    output reg         zero_result_flag_o,     // Zero flag
    output reg         negative_result_flag_o, // Negative flag
    output reg         operand_range_error_flag_o, // Operand range error flag
    output reg         busy_o,                 // Instruction in progress
    output reg         done_o                  // One-cycle completion pulse
);

    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_PTR_A = 3'h1;
    localparam [2:0] ST_PTR_D = 3'h2;
    localparam [2:0] ST_OPD_A = 3'h3;
    localparam [2:0] ST_OPD_D = 3'h4;
    localparam [2:0] ST_EXEC  = 3'h5;
    localparam [2:0] ST_DIV   = 3'h6;

    reg  [2:0]  state_q;
    reg  [2:0]  op_q;
    reg  [15:0] opd_q;
    reg         div_start_q;
    wire        div_done;
    wire [15:0] div_quot;
    wire [15:0] div_rem;
    reg  [31:0] product;
    reg  [31:0] ones_count;
    reg  [31:0] shl_res;
    reg  [31:0] shr_res;
    integer     i;

    // Product of the low accumulator half and the 16-bit operand
    always @* begin
        // Both factors widened on purpose so the full 32-bit product is kept
        product = {16'h0000, acc_o[15:0]} * {16'h0000, opd_q};
    end

    // Count ones across all 32 accumulator bits
    always @* begin
        ones_count = 32'h0000_0000;
        for (i = 0; i < `BMSU_ACC_W; i = i + 1) begin
            ones_count = ones_count + {31'h0, acc_o[i]};
        end
    end

    // Counts of 32 and above empty the accumulator, a count of zero leaves it as is
    always @* begin
        shl_res = acc_o << opd_q;
        shr_res = acc_o >> opd_q;
    end

    // Sequential divider keeps the multiplier array as the only wide arithmetic
    bmsu_divider #(
        .W (`BMSU_OPD_W)
    ) u_div (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .start_i    (div_start_q),
        .dividend_i (acc_o[15:0]),
        .divisor_i  (opd_q),
        .done_o     (div_done),
        .quot_o     (div_quot),
        .rem_o      (div_rem)
    );

    // Instruction sequencing, operand fetch and result write-back
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q                    <= ST_IDLE;
            op_q                       <= `BMSU_OP_MUL;
            opd_q                      <= 16'h0000;
            div_start_q                <= 1'b0;
            mem_rd_o                   <= 1'b0;
            mem_addr_o                 <= {AW{1'b0}};
            acc_o                      <= 32'h0000_0000;
            stack_wr_o                 <= 1'b0;
            stack_data_o               <= 32'h0000_0000;
            zero_result_flag_o         <= 1'b0;
            negative_result_flag_o     <= 1'b0;
            operand_range_error_flag_o <= 1'b0;
            busy_o                     <= 1'b0;
            done_o                     <= 1'b0;
        end else begin
            done_o      <= 1'b0;
            stack_wr_o  <= 1'b0;
            div_start_q <= 1'b0;
            mem_rd_o    <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (start_i) begin
                        op_q   <= op_i;
                        opd_q  <= imm_i;
                        busy_o <= 1'b1;
                        if (op_i == `BMSU_OP_POPCNT || src_i == `BMSU_SRC_IMM) begin
                            state_q <= ST_EXEC;
                        end else if (src_i == `BMSU_SRC_PTR &&
                                     (op_i == `BMSU_OP_SHL || op_i == `BMSU_OP_SHR)) begin
                            // Pointer form of a shift does not exist; finish untouched
                            busy_o  <= 1'b0;
                            done_o  <= 1'b1;
                        end else if (src_i == `BMSU_SRC_PTR) begin
                            mem_rd_o   <= 1'b1;
                            mem_addr_o <= addr_i;
                            state_q    <= ST_PTR_A;
                        end else if (src_i == `BMSU_SRC_DIRECT) begin
                            mem_rd_o   <= 1'b1;
                            mem_addr_o <= addr_i;
                            state_q    <= ST_OPD_A;
                        end else begin
                            // Unused source code: complete without effect
                            busy_o <= 1'b0;
                            done_o <= 1'b1;
                        end
                    end else if (acc_ld_i) begin
                        acc_o <= acc_ld_data_i;
                    end
                end
                ST_PTR_A: begin
                    state_q <= ST_PTR_D;
                end
                ST_PTR_D: begin
                    // The fetched word is the operand's address
                    mem_rd_o   <= 1'b1;
                    mem_addr_o <= mem_rdata_i[AW-1:0];
                    state_q    <= ST_OPD_A;
                end
                ST_OPD_A: begin
                    state_q <= ST_OPD_D;
                end
                ST_OPD_D: begin
                    opd_q   <= mem_rdata_i;
                    state_q <= ST_EXEC;
                end
                ST_EXEC: begin
                    state_q <= ST_IDLE;
                    busy_o  <= 1'b0;
                    done_o  <= 1'b1;
                    case (op_q)
                        `BMSU_OP_MUL: begin
                            acc_o                  <= product;
                            zero_result_flag_o     <= (product == 32'h0000_0000);
                            negative_result_flag_o <= product[`BMSU_SIGN_BIT];
                        end
                        `BMSU_OP_DIV: begin
                            if (opd_q == 16'h0000) begin
                                // A zero divisor cannot be worked; accumulator kept
                                operand_range_error_flag_o <= 1'b1;
                            end else begin
                                div_start_q <= 1'b1;
                                busy_o      <= 1'b1;
                                done_o      <= 1'b0;
                                state_q     <= ST_DIV;
                            end
                        end
                        `BMSU_OP_POPCNT: begin
                            acc_o              <= ones_count;
                            zero_result_flag_o <= (ones_count == 32'h0000_0000);
                        end
                        `BMSU_OP_SHL: begin
                            acc_o                  <= shl_res;
                            zero_result_flag_o     <= (shl_res == 32'h0000_0000);
                            negative_result_flag_o <= shl_res[`BMSU_SIGN_BIT];
                        end
                        `BMSU_OP_SHR: begin
                            acc_o                  <= shr_res;
                            zero_result_flag_o     <= (shr_res == 32'h0000_0000);
                            negative_result_flag_o <= shr_res[`BMSU_SIGN_BIT];
                        end
                        default: begin
                            // Unknown operation: flags and accumulator unchanged
                        end
                    endcase
                end
                ST_DIV: begin
                    if (div_done) begin
                        // Quotient is 16 bits, so the sign bit always clears here
                        acc_o                      <= {16'h0000, div_quot};
                        stack_wr_o                 <= 1'b1;
                        stack_data_o               <= {16'h0000, div_rem};
                        zero_result_flag_o         <= (div_quot == 16'h0000);
                        negative_result_flag_o     <= 1'b0;
                        operand_range_error_flag_o <= 1'b0;
                        busy_o                     <= 1'b0;
                        done_o                     <= 1'b1;
                        state_q                    <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    busy_o  <= 1'b0;
                end
            endcase
        end
    end

endmodule // bmsu_unit

// ==== verification/bmsu_mem_model.sv ====
// Data memory model answering the unit's read strobe
`timescale 1ns/1ps
module bmsu_mem_model (
    input  wire        core_clk_i,  // Core clock
    input  wire        mem_rd_i,    // Read strobe
    input  wire [15:0] mem_addr_i,  // Read address
    output reg  [15:0] mem_rdata_o  // Read data
);
    reg [15:0] mem [0:255];         // Low address bits only
    initial mem_rdata_o = 16'h0000;
    // Valid one cycle after the strobe, else inverted so stale data never passes
    always @(posedge core_clk_i) begin
        if (mem_rd_i)
            mem_rdata_o <= mem[mem_addr_i[7:0]];
        else
            mem_rdata_o <= ~mem_rdata_o;
    end
endmodule // bmsu_mem_model

// ==== verification/bmsu_unit_assertions.sv ====
// Checker for the multiply, divide, bit count and shift unit
`timescale 1ns/1ps
`include "bmsu_defines.vh"
module bmsu_unit_assertions #(
    parameter AW = 16                               // Address width
) (
    input wire          core_clk_i,                 // Clock
    input wire          rst_i,                      // Reset
    input wire          start_i,                    // Start
    input wire [2:0]    op_i,                       // Opcode
    input wire [1:0]    src_i,                      // Source
    input wire [15:0]   imm_i,                      // Immediate
    input wire [AW-1:0] addr_i,                     // Address
    input wire          mem_rd_o,                   // Read strobe
    input wire [AW-1:0] mem_addr_o,                 // Read address
    input wire [31:0]   acc_o,                      // Accumulator
    input wire          stack_wr_o,                 // Stack write
    input wire [31:0]   stack_data_o,               // Remainder
    input wire          zero_result_flag_o,         // Zero
    input wire          negative_result_flag_o,     // Negative
    input wire          operand_range_error_flag_o, // Range error
    input wire          busy_o,                     // Busy
    input wire          done_o                      // Done
);
    reg  [2:0]  op_q;
    reg  [1:0]  src_q;
    reg  [15:0] imm_q;
    reg  [31:0] acc_q;
    wire        take = start_i && !busy_o;
    wire        shf  = op_q == `BMSU_OP_SHL || op_q == `BMSU_OP_SHR;
    // A real result: not refused and not a divide by zero
    wire        eff  = done_o && op_q < 3'h5 && src_q != 2'h3 && !(shf && src_q == `BMSU_SRC_PTR)
                       && !(op_q == `BMSU_OP_DIV && operand_range_error_flag_o);
    wire        imm  = src_q == `BMSU_SRC_IMM;
    // Instruction and old accumulator as seen at the accepting edge
    always @(posedge core_clk_i) begin
        if (take) begin
            op_q  <= op_i;
            src_q <= src_i;
            imm_q <= imm_i;
            acc_q <= acc_o;
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_imm_done;
        busy_o ##1 (done_o && !busy_o);
    endsequence
    sequence s_direct_done;
        mem_rd_o && mem_addr_o == $past(addr_i) ##3 done_o;
    endsequence
    imm_timing_a: assert property (
        take && (op_i == `BMSU_OP_POPCNT || src_i == `BMSU_SRC_IMM && op_i != `BMSU_OP_DIV && op_i < 3'h5)
        |=> s_imm_done) else $error("short op timing");
    direct_read_a: assert property (
        take && src_i == `BMSU_SRC_DIRECT && op_i != `BMSU_OP_DIV && op_i != `BMSU_OP_POPCNT && op_i < 3'h5
        |=> s_direct_done) else $error("direct read timing");
    zero_flag_a: assert property (eff |-> zero_result_flag_o == (acc_o == 32'h0))
        else $error("zero flag wrong");
    neg_flag_a: assert property (eff && op_q != `BMSU_OP_POPCNT |-> negative_result_flag_o == acc_o[31])
        else $error("negative flag wrong");
    pop_count_a: assert property (eff && op_q == `BMSU_OP_POPCNT |-> acc_o == $countones(acc_q))
        else $error("bit count wrong");
    mul_imm_a: assert property (eff && op_q == `BMSU_OP_MUL && imm |-> acc_o == acc_q[15:0] * imm_q)
        else $error("product wrong");
    div_imm_a: assert property (
        eff && op_q == `BMSU_OP_DIV && imm |-> stack_wr_o && acc_o == acc_q[15:0] / imm_q
        && stack_data_o == acc_q[15:0] % imm_q) else $error("quotient or remainder wrong");
    shift_imm_a: assert property (
        eff && shf && imm |-> acc_o == (imm_q > 16'h001f ? 32'h0 : op_q == `BMSU_OP_SHL ? acc_q << imm_q
        : acc_q >> imm_q)) else $error("shift wrong");
    div_zero_a: assert property (
        done_o && op_q == `BMSU_OP_DIV && imm && imm_q == 16'h0000 |-> operand_range_error_flag_o
        && !stack_wr_o && acc_o == acc_q) else $error("divide by zero handling wrong");
    flags_hold_a: assert property (!done_o |-> $stable({zero_result_flag_o, negative_result_flag_o}))
        else $error("flag changed without instruction");
endmodule // bmsu_unit_assertions

bind bmsu_unit bmsu_unit_assertions #(.AW(AW)) bmsu_unit_assertions_inst (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .start_i(start_i), .op_i(op_i), .src_i(src_i), .imm_i(imm_i),
    .addr_i(addr_i), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .acc_o(acc_o), .stack_wr_o(stack_wr_o),
    .stack_data_o(stack_data_o), .zero_result_flag_o(zero_result_flag_o),
    .negative_result_flag_o(negative_result_flag_o), .operand_range_error_flag_o(operand_range_error_flag_o),
    .busy_o(busy_o), .done_o(done_o));

// ==== verification/bmsu_unit_tb.sv ====
// Self-checking bench for the multiply, divide, bit count and shift unit
`timescale 1ns/1ps
`include "bmsu_defines.vh"
module bmsu_unit_tb;
    typedef struct {
        logic [2:0]  op;
        logic [1:0]  src;
        logic [15:0] imm, adr;
        logic [31:0] acc, ea, es;
        logic        z, n;
    } bmsu_row_t;
    bmsu_row_t  rows [0:10];
    reg         core_clk_i = 1'h0;
    reg         rst_i = 1'h1;
    reg         start_i = 1'h0;
    reg  [2:0]  op_i = 3'h0;
    reg  [1:0]  src_i = 2'h0;
    reg  [15:0] imm_i = 16'h0000;
    reg  [15:0] addr_i = 16'h0000;
    reg         acc_ld_i = 1'h0;
    reg  [31:0] acc_ld_data_i = 32'h0;
    wire [15:0] mem_rdata_i, mem_addr_o;
    wire [31:0] acc_o, stack_data_o;
    wire        mem_rd_o, stack_wr_o, zero_f, neg_f, err_f, busy_o, done_o;
    integer     errors = 0;
    integer     check_count = 0;
    integer     i, n;
    always #12.5 core_clk_i = ~core_clk_i;
    bmsu_unit bmsu_unit_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .start_i(start_i), .op_i(op_i),
        .src_i(src_i), .imm_i(imm_i), .addr_i(addr_i), .acc_ld_i(acc_ld_i), .acc_ld_data_i(acc_ld_data_i),
        .mem_rdata_i(mem_rdata_i), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .acc_o(acc_o),
        .stack_wr_o(stack_wr_o), .stack_data_o(stack_data_o), .zero_result_flag_o(zero_f),
        .negative_result_flag_o(neg_f), .operand_range_error_flag_o(err_f), .busy_o(busy_o), .done_o(done_o));
    bmsu_mem_model bmsu_mem_model_inst (.core_clk_i(core_clk_i), .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o),
        .mem_rdata_o(mem_rdata_i));
    task give_verdict;
        begin
            $display("Checks %0d, errors %0d", check_count, errors);
            if (errors == 0 && check_count > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task chk(input logic [35:0] got, input logic [35:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("MISMATCH t=%0t step %0d got %h exp %h", $time, i, got, exp);
            end
        end
    endtask
    // Load accumulator, issue one instruction, wait for done with a bound
    task run(input [2:0] op, input [1:0] src, input [15:0] imm, input [15:0] adr, input [31:0] acc);
        begin
            @(negedge core_clk_i);
            acc_ld_i = 1'h1;
            acc_ld_data_i = acc;
            @(negedge core_clk_i);
            acc_ld_i = 1'h0;
            {start_i, op_i, src_i, imm_i, addr_i} = {1'h1, op, src, imm, adr};
            @(negedge core_clk_i);
            start_i = 1'h0;
            for (n = 0; n < 40 && done_o !== 1'h1; n = n + 1)
                @(negedge core_clk_i);
            if (n == 40) begin
                errors = errors + 1;
                give_verdict;
            end
        end
    endtask
    initial begin
        // Columns: op, source, immediate, address, acc in, acc out, remainder, zero, negative
        rows[0]  = '{3'h0, 2'h2, 16'hffff, 16'h0, 32'h1234ffff, 32'hfffe0001, 32'h0, 1'h0, 1'h1};
        rows[1]  = '{3'h0, 2'h0, 16'h0, 16'h10, 32'h5, 32'hf, 32'h0, 1'h0, 1'h0};
        rows[2]  = '{3'h0, 2'h1, 16'h0, 16'h20, 32'h7, 32'h15, 32'h0, 1'h0, 1'h0};
        rows[3]  = '{3'h1, 2'h2, 16'h7, 16'h0, 32'hffff0064, 32'he, 32'h2, 1'h0, 1'h0};
        rows[4]  = '{3'h1, 2'h0, 16'h0, 16'h30, 32'h5, 32'h0, 32'h5, 1'h1, 1'h0};
        rows[5]  = '{3'h1, 2'h1, 16'h0, 16'h20, 32'h64, 32'h21, 32'h1, 1'h0, 1'h0};
        rows[6]  = '{3'h2, 2'h2, 16'h0, 16'h0, 32'hf0f00001, 32'h9, 32'h0, 1'h0, 1'h0};
        rows[7]  = '{3'h3, 2'h2, 16'h1, 16'h0, 32'hc0000001, 32'h80000002, 32'h0, 1'h0, 1'h1};
        rows[8]  = '{3'h3, 2'h2, 16'h20, 16'h0, 32'hffffffff, 32'h0, 32'h0, 1'h1, 1'h0};
        rows[9]  = '{3'h4, 2'h0, 16'h0, 16'h31, 32'h800000f0, 32'h0800000f, 32'h0, 1'h0, 1'h0};
        rows[10] = '{3'h4, 2'h2, 16'h1f, 16'h0, 32'h80000000, 32'h1, 32'h0, 1'h0, 1'h0};
        bmsu_mem_model_inst.mem[16] = 16'h0003;
        bmsu_mem_model_inst.mem[32] = 16'h0010;
        bmsu_mem_model_inst.mem[48] = 16'h0009;
        bmsu_mem_model_inst.mem[49] = 16'h0004;
        repeat (4) @(negedge core_clk_i);
        rst_i = 1'h0;
        for (i = 0; i < 11; i = i + 1) begin
            run(rows[i].op, rows[i].src, rows[i].imm, rows[i].adr, rows[i].acc);
            chk(acc_o, rows[i].ea);
            chk(zero_f, rows[i].z);
            chk(stack_wr_o, rows[i].op == 3'h1);
            if (rows[i].op != 3'h2)
                chk(neg_f, rows[i].n);
            if (rows[i].op == 3'h1)
                chk(stack_data_o, rows[i].es);
        end
        // Divide by zero must leave acc, zero flag and stack alone
        run(3'h2, 2'h2, 16'h0, 16'h0, 32'h0);
        run(3'h1, 2'h2, 16'h0, 16'h0, 32'h55);
        chk({acc_o, err_f, zero_f, stack_wr_o}, {32'h55, 3'h6});
        run(3'h1, 2'h2, 16'h1, 16'h0, 32'h0);
        chk({acc_o, err_f, zero_f, stack_wr_o}, {32'h0, 3'h3});
        // Shift through a pointer is refused
        run(3'h3, 2'h1, 16'h0, 16'h20, 32'h12);
        chk(acc_o, 32'h12);
        // Undefined operation and source codes complete with no effect
        run(3'h5, 2'h2, 16'h1, 16'h0, 32'h12);
        chk({acc_o, zero_f}, {32'h12, 1'h1});
        run(3'h0, 2'h3, 16'h2, 16'h0, 32'h12);
        chk({acc_o, zero_f}, {32'h12, 1'h1});
        @(negedge core_clk_i);
        rst_i = 1'h1;
        @(negedge core_clk_i);
        chk({acc_o, zero_f, neg_f, err_f, busy_o}, 36'h0);
        // Release reset with the unit idle and take a fresh instruction
        rst_i = 1'h0;
        run(3'h0, 2'h2, 16'h3, 16'h0, 32'h4);
        chk({acc_o, zero_f, neg_f}, {32'hc, 2'h0});
        give_verdict;
    end
endmodule // bmsu_unit_tb
